// file: inc/demag_pkg.sv
package demag_pkg;
  localparam int unsigned data_w = 32;
  localparam int unsigned timer_w = 16;
  localparam int unsigned filt_w = 4;
  // register byte offsets
  localparam logic [7:0] off_ctrl = 8'h00;
  localparam logic [7:0] off_time = 8'h04;
  localparam logic [7:0] off_status = 8'h08;
  localparam logic [7:0] off_mask = 8'h0C;
  localparam logic [7:0] off_phase = 8'h10;
  localparam logic [7:0] off_timer = 8'h14;
  // control field positions
  localparam int unsigned bit_hdm = 0;
  localparam int unsigned bit_sdm = 1;
  localparam int unsigned bit_cpb = 2;
  localparam int unsigned bit_zvd = 3;
  localparam int unsigned bit_sr = 4;
  localparam int unsigned bit_dac = 5;
  localparam int unsigned pos_filt = 8;
  localparam int unsigned bit_timer_run = 12;
  // status and mask field positions
  localparam int unsigned bit_demag = 0;
  localparam int unsigned bit_hw_src = 1;
  localparam int unsigned bit_sim_src = 2;
  localparam logic [2:0] status_used = 3'h7;
  // reset values and response codes
  localparam logic [data_w-1:0] ctrl_reset = 32'h0000_0000;
  localparam logic [timer_w-1:0] time_reset = 16'hFFFF;
  localparam logic [2:0] mask_reset = 3'h0;
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;
endpackage

// file: hdl/demag_filter.sv
module demag_filter #(
  parameter int unsigned filt_w = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic restart,
  input wire logic bypass,
  input wire logic qualify,
  input wire logic [filt_w-1:0] limit,
  output logic hit
);
  logic [filt_w:0] count;
  logic [filt_w:0] target;

  assign target = {1'b0, limit} + {{filt_w{1'b0}}, 1'b1};

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      count <= '0;
      hit <= 1'b0;
    end
    else if (ce)
    begin
      hit <= 1'b0;
      if (restart || !qualify)
      begin
        count <= '0;
      end
      else if (bypass)
      begin
        hit <= 1'b1;
      end
      else if (count + 1'b1 >= target)
      begin
        count <= '0;
        hit <= 1'b1;
      end
      else
      begin
        count <= count + 1'b1;
      end
    end
  end
endmodule // demag_filter

// file: hdl/demag_edge_detect.sv
module demag_edge_detect (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic sensing_input,
  input wire logic compare_edge_sel,
  input wire logic edge_relation_sel,
  output logic qualify
);
  logic prev;
  logic want_high;

  // demag uses opposite polarity to zero-crossing unless relation bit set
  assign want_high = edge_relation_sel ? compare_edge_sel : !compare_edge_sel;
  assign qualify = (sensing_input == want_high) && (prev != want_high);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      prev <= 1'b0;
    end
    else if (ce)
    begin
      if (sensing_input == want_high && prev != want_high)
      begin
        prev <= prev;
      end
      else
      begin
        prev <= sensing_input;
      end
    end
  end
endmodule // demag_edge_detect

// file: hdl/demag_event_generator.sv
// Summary of operation
// - a voltage edge of the chosen polarity on the sensing input raises a hardware demag event.
// - the hardware event fires only after the filter counts enough consecutive samples.
// - filter field n gives a limit of n+1 samples; position sensor mode suppresses every demag event, hardware and simulated.
// - with hardware capture on, each hardware event copies the step timer into the time register.
// - with simulation on, a step timer match with the time register makes a simulated event.
// - with both modes on, the first event of the step is the demag event.
// - with only simulation on, the simulated event enables zero-crossing, which commutation disables.
// - any demag event sets the demag flag and requests an interrupt when unmasked.
// - right after commutation a time register at or below the timer fires the simulated event.
// - that immediate firing overwrites the time register with the current timer value.
// - preloaded control bits apply at commutation, or on a phase write in direct access mode.
// - the edge relation bit picks opposite or identical polarity to zero-crossing.
//
// The implementer's own choices: the register addresses and register access over AXI4-Lite.
module demag_event_generator #(
  parameter int unsigned timer_w = demag_pkg::timer_w,
  parameter int unsigned filt_w = demag_pkg::filt_w
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic sensing_input,
  input wire logic commutation_event,
  input wire logic sample_strobe,
  output logic demag_event,
  output logic zc_enable,
  output logic irq,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  typedef enum logic [1:0] {st_wait, st_check, st_armed, st_done} step_t;
  step_t step;

  logic [31:0] control_reg_b;
  logic [31:0] active_ctrl;
  logic [timer_w-1:0] demag_time_reg;
  logic [timer_w-1:0] step_timer;
  logic [2:0] irq_status_reg;
  logic [2:0] irq_mask_reg;
  logic [7:0] phase_state_reg;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic aw_held;
  logic w_held;
  logic do_write;
  logic hw_hit;
  logic qualify;
  logic stale;
  logic hw_en;
  logic sim_en;
  logic sensor_mode;
  logic hw_ev;
  logic sim_ev;
  logic early_ev;
  logic any_ev;
  logic phase_wr;
  logic time_wr;
  logic [31:0] wmask;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;

  assign hw_en = active_ctrl[demag_pkg::bit_hdm];
  assign sim_en = active_ctrl[demag_pkg::bit_sdm];
  assign sensor_mode = active_ctrl[demag_pkg::bit_sr];

  demag_edge_detect u_edge (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce && sample_strobe),
    .sensing_input(sensing_input),
    .compare_edge_sel(active_ctrl[demag_pkg::bit_cpb]),
    .edge_relation_sel(active_ctrl[demag_pkg::bit_zvd]),
    .qualify(qualify)
  );

  demag_filter #(.filt_w(filt_w)) u_filter (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce && sample_strobe),
    .restart(commutation_event),
    .bypass(sensor_mode),
    .qualify(qualify && !stale && step == st_armed),
    .limit(active_ctrl[demag_pkg::pos_filt +: filt_w]),
    .hit(hw_hit)
  );

  // an edge still latched at commutation belongs to the previous step
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      stale <= 1'b0;
    end
    else if (ce)
    begin
      if (commutation_event)
      begin
        stale <= qualify;
      end
      else if (!qualify)
      begin
        stale <= 1'b0;
      end
    end
  end

  // event qualification
  assign hw_ev = hw_hit && (step == st_armed) && !sensor_mode
    && (hw_en || !sim_en);
  assign sim_ev = sim_en && !sensor_mode && (step == st_armed)
    && (step_timer == demag_time_reg);
  assign early_ev = sim_en && !sensor_mode && (step == st_check)
    && (demag_time_reg <= step_timer);
  assign any_ev = ce && (hw_ev || sim_ev || early_ev);

  // write channel
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= demag_pkg::resp_okay;
    end
    else if (ce)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case (aw_addr)
          demag_pkg::off_ctrl, demag_pkg::off_time, demag_pkg::off_status,
          demag_pkg::off_mask, demag_pkg::off_phase:
            s_axi_bresp <= demag_pkg::resp_okay;
          default:
            s_axi_bresp <= demag_pkg::resp_slverr;
        endcase
      end
      else if (s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
  assign phase_wr = ce && do_write && aw_addr == demag_pkg::off_phase;
  assign time_wr = ce && do_write && aw_addr == demag_pkg::off_time;

  // control preload and active copy
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      control_reg_b <= demag_pkg::ctrl_reset;
      active_ctrl <= demag_pkg::ctrl_reset;
      phase_state_reg <= 8'h00;
    end
    else if (ce)
    begin
      if (do_write && aw_addr == demag_pkg::off_ctrl)
      begin
        control_reg_b <= (control_reg_b & ~wmask) | (w_data & wmask);
      end
      if (phase_wr)
      begin
        phase_state_reg <= w_data[7:0];
      end
      if (control_reg_b[demag_pkg::bit_dac] ? phase_wr : commutation_event)
      begin
        active_ctrl <= control_reg_b;
      end
    end
  end

  // step timer restarts at each commutation
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      step_timer <= '0;
    end
    else if (ce)
    begin
      if (commutation_event)
      begin
        step_timer <= '0;
      end
      else if (active_ctrl[demag_pkg::bit_timer_run] && step_timer != '1)
      begin
        step_timer <= step_timer + 1'b1;
      end
    end
  end

  // step sequencer
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      step <= st_wait;
    end
    else if (ce)
    begin
      if (commutation_event)
      begin
        step <= st_check;
      end
      else
      begin
        case (step)
          st_wait: step <= st_wait;
          st_check: step <= early_ev ? st_done : st_armed;
          st_armed: step <= (hw_ev || sim_ev) ? st_done : st_armed;
          st_done: step <= st_done;
          default: step <= st_wait;
        endcase
      end
    end
  end

  // time register: capture, early overwrite, software write
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      demag_time_reg <= demag_pkg::time_reset;
    end
    else if (ce)
    begin
      if (early_ev)
      begin
        demag_time_reg <= step_timer;
      end
      else if (hw_ev && hw_en)
      begin
        demag_time_reg <= step_timer;
      end
      else if (time_wr)
      begin
        demag_time_reg <= (demag_time_reg & ~wmask[timer_w-1:0])
          | (w_data[timer_w-1:0] & wmask[timer_w-1:0]);
      end
    end
  end

  // status, mask, outputs
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_status_reg <= 3'h0;
      irq_mask_reg <= demag_pkg::mask_reset;
      demag_event <= 1'b0;
      zc_enable <= 1'b0;
    end
    else if (ce)
    begin
      if (do_write && aw_addr == demag_pkg::off_mask && w_strb[0])
      begin
        irq_mask_reg <= w_data[2:0] & demag_pkg::status_used;
      end
      irq_status_reg <= (irq_status_reg
        & ~((do_write && aw_addr == demag_pkg::off_status && w_strb[0]) ? w_data[2:0] : 3'h0))
        | {sim_ev || early_ev, hw_ev, any_ev};
      demag_event <= any_ev;
      if (commutation_event)
      begin
        zc_enable <= 1'b0;
      end
      else if (any_ev)
      begin
        zc_enable <= 1'b1;
      end
    end
  end

  assign irq = |(irq_status_reg & irq_mask_reg);

  // read channel
  always_comb
  begin
    next_rresp = demag_pkg::resp_okay;
    case (s_axi_araddr)
      demag_pkg::off_ctrl: next_rdata = control_reg_b;
      demag_pkg::off_time: next_rdata = {{(32 - timer_w){1'b0}}, demag_time_reg};
      demag_pkg::off_status: next_rdata = {29'h0, irq_status_reg};
      demag_pkg::off_mask: next_rdata = {29'h0, irq_mask_reg};
      demag_pkg::off_phase: next_rdata = {24'h0, phase_state_reg};
      demag_pkg::off_timer: next_rdata = {{(32 - timer_w){1'b0}}, step_timer};
      default:
      begin
        next_rdata = 32'h0000_0000;
        next_rresp = demag_pkg::resp_slverr;
      end
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= demag_pkg::resp_okay;
    end
    else if (ce)
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= next_rdata;
        s_axi_rresp <= next_rresp;
      end
      else if (s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  assign s_axi_arready = !s_axi_rvalid;
endmodule // demag_event_generator

// file: verif/demag_event_generator_asserts.sv
module demag_event_generator_asserts (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic commutation_event,
  input wire logic demag_event,
  input wire logic zc_enable,
  input wire logic irq,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic seen;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn || !ce);
  // event already given in this step
  always_ff @(posedge aclk)
  begin
    if (!aresetn || commutation_event)
      seen <= 1'b0;
    else if (demag_event)
      seen <= 1'b1;
  end
  a_pulse_once: assert property (demag_event |=> !demag_event)
    else $error("event pulse too long");
  a_one_per_step: assert property (seen && !commutation_event |-> !demag_event)
    else $error("second event in step");
  a_zc_rise: assert property ($rose(zc_enable) |-> demag_event || $past(demag_event))
    else $error("zc enable without event");
  a_zc_follow: assert property (demag_event |-> ##[0:1] zc_enable)
    else $error("zc enable missing");
  a_zc_fall: assert property ($fell(zc_enable) |-> $past(commutation_event) || $past(commutation_event, 2))
    else $error("zc enable dropped early");
  a_irq_raise: assert property ($rose(irq) |-> (!s_axi_awready || !$past(s_axi_awready) ||
    s_axi_bvalid || $past(demag_event)) or ##[0:1] demag_event)
    else $error("irq without cause");
  a_irq_drop: assert property ($fell(irq) |-> !s_axi_awready || !$past(s_axi_awready) || s_axi_bvalid)
    else $error("irq dropped without write");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  a_resp_taken: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not released");
endmodule // demag_event_generator_asserts

bind demag_event_generator demag_event_generator_asserts chk_i (.aclk(aclk), .aresetn(aresetn),
  .ce(ce), .commutation_event(commutation_event), .demag_event(demag_event),
  .zc_enable(zc_enable), .irq(irq), .s_axi_awready(s_axi_awready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready));

// file: verif/motor_phase_model.sv
module motor_phase_model (
  input wire logic aclk,
  input wire logic go,
  input wire logic edge_dir,
  input wire logic [7:0] delay,
  output logic sensing_input = 1'b0,
  output logic commutation_event = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  // level opposite to the edge, commutation, then the edge after delay
  always @(posedge aclk)
  begin
    commutation_event <= 1'b0;
    if (go)
    begin
      sensing_input <= !edge_dir;
      cnt <= 1;
    end
    else if (cnt != 0)
    begin
      cnt <= cnt + 1;
      if (cnt == 4)
        commutation_event <= 1'b1;
      if (cnt == 4 + delay)
      begin
        sensing_input <= edge_dir;
        cnt <= 0;
      end
    end
  end
endmodule // motor_phase_model

// file: verif/tb_demag_event_generator.sv
module tb_demag_event_generator;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic ce = 1'b1;
  logic sample_strobe = 1'b1;
  logic sensing_input, commutation_event, demag_event, zc_enable, irq;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [31:0] s_axi_rdata, v, cap0, cap7;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp, r, wb;
  logic go = 1'b0;
  logic edge_dir = 1'b0;
  logic [7:0] delay = 8'h00;
  logic g;
  logic [3:0] fired;
  int err_count = 0;
  int check_count = 0;
  int n, n0, n7, nh, ns;
  demag_event_generator uut (.aclk(aclk), .aresetn(aresetn), .ce(ce), .sensing_input(sensing_input),
    .commutation_event(commutation_event), .sample_strobe(sample_strobe),
    .demag_event(demag_event), .zc_enable(zc_enable), .irq(irq),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
  motor_phase_model partner (.aclk(aclk), .go(go), .edge_dir(edge_dir), .delay(delay),
    .sensing_input(sensing_input), .commutation_event(commutation_event));
  initial
  begin
    forever #12.5 aclk = ~aclk;
  end
  task summarize;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    int k;
    logic bp;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    bp = 1'b1;
    for (k = 0; k < 50 && bp; k++)
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      bp = !s_axi_bvalid;
      wb = s_axi_bresp;
      s_axi_bready <= !s_axi_bvalid;
    end
    if (bp)
      err_count++;
  endtask
  task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rr);
    int k;
    logic bp;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    bp = 1'b1;
    for (k = 0; k < 50 && bp; k++)
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      bp = !s_axi_rvalid;
      d = s_axi_rdata;
      rr = s_axi_rresp;
      s_axi_rready <= !s_axi_rvalid;
    end
    if (bp)
      err_count++;
  endtask
  // cycles from commutation to the event, -1 when none
  task step(input logic dir, input logic [7:0] dly, output int cnt);
    @(posedge aclk);
    go <= 1'b1;
    edge_dir <= dir;
    delay <= dly;
    @(posedge aclk);
    go <= 1'b0;
    do
      @(negedge aclk);
    while (commutation_event !== 1'b1);
    cnt = 0;
    do
    begin
      @(negedge aclk);
      cnt++;
    end
    while (demag_event !== 1'b1 && cnt < 90);
    if (cnt == 90)
      cnt = -1;
    repeat (20) @(posedge aclk);
  endtask
  // first step loads the preloaded control, second is measured
  task cfg(input logic [31:0] c, input logic dir, input logic [7:0] dly, output int cnt);
    wr(demag_pkg::off_ctrl, c);
    step(dir, dly, cnt);
    step(dir, dly, cnt);
  endtask
  initial
  begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(demag_pkg::off_ctrl, v, r);
    chk(v, demag_pkg::ctrl_reset);
    rd(demag_pkg::off_time, v, r);
    chk(v, 32'h0000_FFFF);
    rd(8'h40, v, r);
    chk(r, demag_pkg::resp_slverr);
    wr(demag_pkg::off_timer, 32'h0000_0001);
    chk(wb, demag_pkg::resp_slverr);
    wr(demag_pkg::off_mask, 32'h0000_0000);
    chk(wb, demag_pkg::resp_okay);
    for (int i = 0; i < 4; i++)
    begin
      cfg(i[1] ? 32'h0000_1005 : 32'h0000_1001, i[0], 8'h0A, n);
      fired[i] = n > 0;
    end
    chk(fired[0] ^ fired[1], 1'b1);
    chk(fired[2], fired[1]);
    cfg(32'h0000_1009, 1'b1, 8'h0A, n);
    chk(n > 0, fired[0]);
    g = fired[1];
    cfg(32'h0000_1001, g, 8'h0A, nh);
    rd(demag_pkg::off_time, cap0, r);
    cfg(32'h0000_1701, g, 8'h0A, n7);
    rd(demag_pkg::off_time, cap7, r);
    chk(n7 - nh, 7);
    chk(cap7 - cap0, 7);
    cfg(32'h0000_1711, g, 8'h0A, n);
    chk(n, -1);
    wr(demag_pkg::off_status, 32'h0000_0007);
    wr(demag_pkg::off_time, 32'h0000_000A);
    cfg(32'h0000_1002, !g, 8'hC8, ns);
    chk(zc_enable, 1'b1);
    wr(demag_pkg::off_time, 32'h0000_001E);
    step(!g, 8'hC8, n);
    chk(n - ns, 20);
    rd(demag_pkg::off_status, v, r);
    chk(v, 32'h0000_0005);
    chk(irq, 1'b0);
    wr(demag_pkg::off_mask, 32'h0000_0001);
    chk(irq, 1'b1);
    wr(demag_pkg::off_status, 32'h0000_0007);
    chk(irq, 1'b0);
    wr(demag_pkg::off_time, 32'h0000_0000);
    step(!g, 8'hC8, n);
    chk(n, 2);
    wr(demag_pkg::off_ctrl, 32'h0000_1003);
    step(g, 8'h0A, n);
    wr(demag_pkg::off_time, 32'h0000_001E);
    step(g, 8'h0A, n);
    chk(n, nh);
    wr(demag_pkg::off_time, 32'h0000_0005);
    step(g, 8'h28, n);
    chk(n, ns - 5);
    wr(demag_pkg::off_ctrl, 32'h0000_1721);
    wr(demag_pkg::off_phase, 32'h0000_005A);
    rd(demag_pkg::off_phase, v, r);
    chk(v, 32'h0000_005A);
    step(g, 8'h0A, n);
    chk(n, n7);
    rd(demag_pkg::off_timer, v, r);
    @(posedge aclk);
    ce <= 1'b0;
    repeat (10) @(posedge aclk);
    ce <= 1'b1;
    rd(demag_pkg::off_timer, cap0, r);
    chk(cap0 - v, 32'h0000_0004);
    summarize();
  end
  initial
  begin
    repeat (40000) @(posedge aclk);
    err_count++;
    summarize();
  end
endmodule // tb_demag_event_generator
